// ==== pkg/clce_pkg.sv ====
`default_nettype none
package clce_pkg;
    localparam int OPC_W = 9;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    // Parallel bitwise-logic contacts
    localparam logic [8:0] OPC_PAR_AND = 9'h0dd;
    localparam logic [8:0] OPC_PAR_OR = 9'h0de;
    localparam logic [8:0] OPC_PAR_XOR = 9'h0df;
    // Rung-start compare contacts
    localparam logic [8:0] OPC_RS_EQ = 9'h0e0;
    localparam logic [8:0] OPC_RS_GT = 9'h0e1;
    localparam logic [8:0] OPC_RS_LT = 9'h0e2;
    localparam logic [8:0] OPC_RS_NE = 9'h0e4;
    localparam logic [8:0] OPC_RS_LE = 9'h0e5;
    localparam logic [8:0] OPC_RS_GE = 9'h0e6;
    // Series compare contacts
    localparam logic [8:0] OPC_SR_EQ = 9'h0e8;
    localparam logic [8:0] OPC_SR_GT = 9'h0e9;
    localparam logic [8:0] OPC_SR_LT = 9'h0ea;
    localparam logic [8:0] OPC_SR_NE = 9'h0ec;
    localparam logic [8:0] OPC_SR_LE = 9'h0ed;
    localparam logic [8:0] OPC_SR_GE = 9'h0ee;
    // Program steps per instruction form
    localparam logic [3:0] STEPS_16 = 4'h5;
    localparam logic [3:0] STEPS_32 = 4'h9;
    typedef enum logic [2:0] {CLCE_EQ, CLCE_GT, CLCE_LT, CLCE_NE, CLCE_LE, CLCE_GE} clce_rel_e;
endpackage : clce_pkg
`default_nettype wire

// ==== rtl/clce_contact_eval.sv ====
// Functional notes
// RULE1 - Logic contact combines operands bitwise; active when result non-zero.
// RULE2 - Parallel logic opcodes: 221 AND, 222 OR, 223 XOR.
// RULE3 - Parallel logic result is ORed with incoming rung state.
// RULE4 - Rung-start compares: 224 eq,225 gt,226 lt,228 ne,229 le,230 ge.
// RULE5 - Rung-start compare takes power from busbar, ignoring prior rung.
// RULE6 - Series compares: 232 eq,233 gt,234 lt,236 ne,237 le,238 ge.
// RULE7 - Series compare result is ANDed with incoming rung state.
// RULE8 - 16-bit form is 5 program steps, 32-bit form 9 steps.
// RULE9 - 32-bit operand: named register low word, next register high word.
// RULE10 - Magnitude compares are signed.
// RULE11 - Two source operands; only a contact state results, no register write.
// RULE12 - Result produced for the step in which opcode and operands arrive.
`default_nettype none
module clce_contact_eval
    import clce_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [clce_pkg::OPC_W-1:0] opcode,
    input wire logic dword,
    input wire logic [clce_pkg::WORD_W-1:0] first_src_lo,
    input wire logic [clce_pkg::WORD_W-1:0] first_src_hi,
    input wire logic [clce_pkg::WORD_W-1:0] second_src_lo,
    input wire logic [clce_pkg::WORD_W-1:0] second_src_hi,
    input wire logic rung_in,
    output logic out_valid,
    output logic rung_out,
    output logic contact,
    output logic bad_opcode,
    output logic [3:0] step_len
);
    import clce_pkg::*;

    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Signed relation on 32 bits; 16-bit operands arrive sign-extended
    function automatic logic rel_holds(input clce_rel_e rel, input logic signed [31:0] a,
                                       input logic signed [31:0] b);
        case (rel)
            CLCE_EQ: rel_holds = (a == b);
            CLCE_GT: rel_holds = (a > b);
            CLCE_LT: rel_holds = (a < b);
            CLCE_NE: rel_holds = (a != b);
            CLCE_LE: rel_holds = (a <= b);
            CLCE_GE: rel_holds = (a >= b);
            default: rel_holds = 1'b0;
        endcase
    endfunction : rel_holds

    logic signed [31:0] op_a;
    logic signed [31:0] op_b;
    logic next_out_valid;
    logic next_rung_out;
    logic next_contact;
    logic next_bad_opcode;
    logic [3:0] next_step_len;

    always_comb begin
        // Low word from named register, high word from the next one
        op_a = dword ? $signed({first_src_hi, first_src_lo})
                     : $signed({{16{first_src_lo[15]}}, first_src_lo}); // RULE9 RULE10
        op_b = dword ? $signed({second_src_hi, second_src_lo})
                     : $signed({{16{second_src_lo[15]}}, second_src_lo}); // RULE9 RULE10
        next_out_valid = in_valid; // RULE12
        next_step_len = dword ? STEPS_32 : STEPS_16; // RULE8
        next_contact = 1'b0;
        next_rung_out = rung_in;
        next_bad_opcode = 1'b0;
        // Only a contact state leaves the block, nothing is written back
        case (opcode) // RULE11
            OPC_PAR_AND: next_contact = |(op_a & op_b); // RULE1 RULE2
            OPC_PAR_OR: next_contact = |(op_a | op_b); // RULE1 RULE2
            OPC_PAR_XOR: next_contact = |(op_a ^ op_b); // RULE1 RULE2
            OPC_RS_EQ: next_contact = rel_holds(CLCE_EQ, op_a, op_b); // RULE4
            OPC_RS_GT: next_contact = rel_holds(CLCE_GT, op_a, op_b); // RULE4
            OPC_RS_LT: next_contact = rel_holds(CLCE_LT, op_a, op_b); // RULE4
            OPC_RS_NE: next_contact = rel_holds(CLCE_NE, op_a, op_b); // RULE4
            OPC_RS_LE: next_contact = rel_holds(CLCE_LE, op_a, op_b); // RULE4
            OPC_RS_GE: next_contact = rel_holds(CLCE_GE, op_a, op_b); // RULE4
            OPC_SR_EQ: next_contact = rel_holds(CLCE_EQ, op_a, op_b); // RULE6
            OPC_SR_GT: next_contact = rel_holds(CLCE_GT, op_a, op_b); // RULE6
            OPC_SR_LT: next_contact = rel_holds(CLCE_LT, op_a, op_b); // RULE6
            OPC_SR_NE: next_contact = rel_holds(CLCE_NE, op_a, op_b); // RULE6
            OPC_SR_LE: next_contact = rel_holds(CLCE_LE, op_a, op_b); // RULE6
            OPC_SR_GE: next_contact = rel_holds(CLCE_GE, op_a, op_b); // RULE6
            default: next_bad_opcode = in_valid;
        endcase
        // Unknown opcode passes the rung untouched rather than dropping power
        if (next_bad_opcode) begin
            next_rung_out = rung_in;
        end else if (opcode >= OPC_PAR_AND && opcode <= OPC_PAR_XOR) begin
            next_rung_out = rung_in | next_contact; // RULE3
        end else if (opcode >= OPC_RS_EQ && opcode <= OPC_RS_GE) begin
            next_rung_out = next_contact; // RULE5
        end else if (opcode >= OPC_SR_EQ && opcode <= OPC_SR_GE) begin
            next_rung_out = rung_in & next_contact; // RULE7
        end
        if (!in_valid) begin
            next_rung_out = 1'b0;
            next_contact = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            rung_out <= 1'b0;
            contact <= 1'b0;
            bad_opcode <= 1'b0;
            step_len <= 4'h0;
        end else if (!rst_sync) begin
            out_valid <= 1'b0;
            rung_out <= 1'b0;
            contact <= 1'b0;
            bad_opcode <= 1'b0;
            step_len <= 4'h0;
        end else begin
            out_valid <= next_out_valid;
            rung_out <= next_rung_out;
            contact <= next_contact;
            bad_opcode <= next_bad_opcode;
            step_len <= next_step_len;
        end
    end

    property p_valid_follows;
        @(posedge clk) disable iff (!rst_sync)
        in_valid |=> out_valid;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("No result after request"); // RULE12

    property p_par_and;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_PAR_AND && !dword)
            |=> contact == $past(|(first_src_lo & second_src_lo));
    endproperty
    a_par_and: assert property (p_par_and) else $error("AND contact wrong"); // RULE1

    property p_par_or_rung;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_PAR_XOR && rung_in) |=> rung_out;
    endproperty
    a_par_or_rung: assert property (p_par_or_rung) else $error("Parallel path lost"); // RULE3

    property p_rs_busbar;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_RS_NE) |=> rung_out == contact;
    endproperty
    a_rs_busbar: assert property (p_rs_busbar) else $error("Rung start not from busbar"); // RULE5

    property p_rs_gt_signed;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_RS_GT && !dword)
            |=> contact == ($past($signed(first_src_lo)) > $past($signed(second_src_lo)));
    endproperty
    a_rs_gt_signed: assert property (p_rs_gt_signed) else $error("Signed compare wrong"); // RULE10

    property p_sr_and;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_SR_EQ && !rung_in) |=> !rung_out;
    endproperty
    a_sr_and: assert property (p_sr_and) else $error("Series contact ignores rung"); // RULE7

    property p_sr_ge;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_SR_GE && dword && {first_src_hi, first_src_lo} ==
            {second_src_hi, second_src_lo}) |=> contact;
    endproperty
    a_sr_ge: assert property (p_sr_ge) else $error("Series GE failed on equal"); // RULE6 RULE9

    property p_steps;
        @(posedge clk) disable iff (!rst_sync)
        in_valid |=> step_len == ($past(dword) ? 4'h9 : 4'h5);
    endproperty
    a_steps: assert property (p_steps) else $error("Step count wrong"); // RULE8

    property p_rs_le;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_RS_LE && !dword && first_src_lo == second_src_lo)
            |=> contact && !bad_opcode;
    endproperty
    a_rs_le: assert property (p_rs_le) else $error("LE failed on equal"); // RULE4

    property p_gap_bad;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == 9'h0e3) |=> bad_opcode && !contact;
    endproperty
    a_gap_bad: assert property (p_gap_bad) else $error("Gap opcode accepted"); // RULE2 RULE11

    sequence s_take_par;
        in_valid && opcode >= OPC_PAR_AND && opcode <= OPC_PAR_XOR;
    endsequence

    sequence s_take_rs;
        in_valid && opcode >= OPC_RS_EQ && opcode <= OPC_RS_GE && opcode != 9'h0e3;
    endsequence

    sequence s_take_sr;
        in_valid && opcode >= OPC_SR_EQ && opcode <= OPC_SR_GE && opcode != 9'h0eb;
    endsequence

    sequence s_take_undecoded;
        in_valid && (opcode == 9'h0e3 || opcode == 9'h0e7 || opcode == 9'h0eb);
    endsequence

    property p_par_rung;
        @(posedge clk) disable iff (!rst_sync)
        s_take_par |=> rung_out == ($past(rung_in) || contact);
    endproperty
    a_par_rung: assert property (p_par_rung) else $error("Parallel rung wrong"); // RULE3

    property p_par_or_16;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_PAR_OR && !dword)
            |=> contact == (|($past(first_src_lo) | $past(second_src_lo)));
    endproperty
    a_par_or_16: assert property (p_par_or_16) else $error("OR contact wrong"); // RULE1 RULE2

    property p_par_xor_16;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_PAR_XOR && !dword)
            |=> contact == (|($past(first_src_lo) ^ $past(second_src_lo)));
    endproperty
    a_par_xor_16: assert property (p_par_xor_16) else $error("XOR contact wrong"); // RULE1 RULE2

    property p_par_dword_hi;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_PAR_AND && dword && |(first_src_hi & second_src_hi))
            |=> contact;
    endproperty
    a_par_dword_hi: assert property (p_par_dword_hi) else $error("High word ignored"); // RULE9

    property p_rs_rung;
        @(posedge clk) disable iff (!rst_sync)
        s_take_rs |=> rung_out == contact;
    endproperty
    a_rs_rung: assert property (p_rs_rung) else $error("Rung start used old rung"); // RULE5

    property p_rs_eq_16;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_RS_EQ && !dword)
            |=> contact == ($past(first_src_lo) == $past(second_src_lo));
    endproperty
    a_rs_eq_16: assert property (p_rs_eq_16) else $error("EQ compare wrong"); // RULE4

    property p_rs_lt_signed;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_RS_LT && !dword)
            |=> contact == ($signed($past(first_src_lo)) < $signed($past(second_src_lo)));
    endproperty
    a_rs_lt_signed: assert property (p_rs_lt_signed) else $error("Signed LT wrong"); // RULE10

    property p_sr_rung;
        @(posedge clk) disable iff (!rst_sync)
        s_take_sr |=> rung_out == ($past(rung_in) && contact);
    endproperty
    a_sr_rung: assert property (p_sr_rung) else $error("Series rung wrong"); // RULE7

    property p_sr_gt_dword;
        @(posedge clk) disable iff (!rst_sync)
        (in_valid && opcode == OPC_SR_GT && dword)
            |=> contact == ($signed({$past(first_src_hi), $past(first_src_lo)})
                > $signed({$past(second_src_hi), $past(second_src_lo)}));
    endproperty
    a_sr_gt_dword: assert property (p_sr_gt_dword) else $error("Wide GT wrong"); // RULE6 RULE9

    property p_undecoded;
        @(posedge clk) disable iff (!rst_sync)
        s_take_undecoded |=> bad_opcode && !contact && rung_out == $past(rung_in);
    endproperty
    a_undecoded: assert property (p_undecoded) else $error("Gap opcode disturbs rung"); // RULE2

    property p_rs_decoded;
        @(posedge clk) disable iff (!rst_sync)
        s_take_rs |=> !bad_opcode;
    endproperty
    a_rs_decoded: assert property (p_rs_decoded) else $error("Rung start flagged bad"); // RULE4

    property p_sr_decoded;
        @(posedge clk) disable iff (!rst_sync)
        s_take_sr |=> !bad_opcode;
    endproperty
    a_sr_decoded: assert property (p_sr_decoded) else $error("Series compare flagged bad"); // RULE6

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_sync)
        !in_valid |=> !out_valid && !contact && !rung_out && !bad_opcode;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Output without request"); // RULE12
endmodule : clce_contact_eval
`default_nettype wire

// ==== sim/clce_seq_model.sv ====
`default_nettype none
module clce_seq_model
    import clce_pkg::*;
(
    input wire logic clk,
    output logic in_valid,
    output logic [clce_pkg::OPC_W-1:0] opcode,
    output logic dword,
    output logic [31:0] first_src,
    output logic [31:0] second_src,
    output logic rung_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        in_valid = 1'h0;
        opcode = '0;
        dword = 1'h0;
        first_src = '0;
        second_src = '0;
        rung_in = 1'h0;
    end
    // Two operands and the rung state with every instruction
    task automatic issue(input logic [8:0] op, input logic dw, input logic [31:0] a,
                         input logic [31:0] b, input logic r);
        @(posedge clk);
        in_valid <= 1'h1;
        opcode <= op;
        dword <= dw;
        first_src <= a;
        second_src <= b;
        rung_in <= r;
    endtask : issue
    // Released operand and rung lines toggle so stale data cannot look valid
    task automatic idle();
        @(posedge clk);
        in_valid <= 1'h0;
        first_src <= ~first_src;
        second_src <= ~second_src;
        rung_in <= ~rung_in;
    endtask : idle
endmodule : clce_seq_model
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Flags: dword, rung in, contact, rung out
    typedef struct {logic [8:0] op; logic [31:0] a; logic [31:0] b; logic [3:0] f;} clce_row_s;
    clce_row_s rows [19] = '{
        '{9'h0dd, 32'h555500f0, 32'h00000f0f, 4'h5}, '{9'h0dd, 32'h00010000, 32'h00010000, 4'hb},
        '{9'h0de, 32'hffff0000, 32'h00000000, 4'h0}, '{9'h0de, 32'h00000000, 32'h00000001, 4'h3},
        '{9'h0df, 32'h000000ff, 32'h000000ff, 4'h0}, '{9'h0df, 32'h010000ff, 32'h000000ff, 4'hb},
        '{9'h0e0, 32'h7fffffe2, 32'h000000c8, 4'h4}, '{9'h0e1, 32'h7fffffe2, 32'h000000c8, 4'h4},
        '{9'h0e2, 32'h7fffffe2, 32'h000000c8, 4'h7}, '{9'h0e4, 32'h7fffffe2, 32'h000000c8, 4'h7},
        '{9'h0e5, 32'h7fffffe2, 32'h000000c8, 4'h7}, '{9'h0e6, 32'h7fffffe2, 32'h000000c8, 4'h4},
        '{9'h0e8, 32'hffffffe2, 32'hffffffe2, 4'ha}, '{9'h0e9, 32'h000000c8, 32'hffffffe2, 4'hf},
        '{9'h0ea, 32'h000000c8, 32'hffffffe2, 4'hc}, '{9'h0ec, 32'h000000c8, 32'hffffffe2, 4'hf},
        '{9'h0ed, 32'h000000c8, 32'hffffffe2, 4'hc}, '{9'h0ee, 32'h7fffffe2, 32'h0000ffe2, 4'h7},
        '{9'h0e3, 32'h7fffffe2, 32'h000000c8, 4'h5}};
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic in_valid, dword, rung_in, out_valid, rung_out, contact, bad_opcode;
    logic [8:0] opcode;
    logic [31:0] a, b;
    logic [3:0] step_len;
    int bad_count = 0;
    int num_checks = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    clce_seq_model i_seq (.clk(clk), .in_valid(in_valid), .opcode(opcode), .dword(dword),
        .first_src(a), .second_src(b), .rung_in(rung_in));
    clce_contact_eval i_dut (.clk(clk), .rstn(rstn), .in_valid(in_valid), .opcode(opcode),
        .dword(dword), .first_src_lo(a[15:0]), .first_src_hi(a[31:16]),
        .second_src_lo(b[15:0]), .second_src_hi(b[31:16]), .rung_in(rung_in),
        .out_valid(out_valid), .rung_out(rung_out), .contact(contact),
        .bad_opcode(bad_opcode), .step_len(step_len));
    task automatic send(input clce_row_s r);
        i_seq.issue(r.op, r.f[3], r.a, r.b, r.f[2]);
    endtask : send
    task automatic chk_row(input clce_row_s r);
        `CHK(out_valid, 1'h1)
        `CHK(contact, r.f[1])
        `CHK(rung_out, r.f[0])
        `CHK(bad_opcode, r.op === 9'h0e3)
        `CHK(step_len, r.f[3] ? 4'h9 : 4'h5)
    endtask : chk_row
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            send(rows[i]);
            i_seq.idle();
            #1 chk_row(rows[i]);
        end
        $display("table test done");
        // Back to back: second request must not disturb the first result
        send(rows[8]);
        send(rows[14]);
        #1 chk_row(rows[8]);
        i_seq.idle();
        #1 chk_row(rows[14]);
        i_seq.idle();
        #1 `CHK(out_valid, 1'h0)
        $display("back to back test done");
        send(rows[1]);
        @(posedge clk);
        rstn <= 1'h0;
        #1 `CHK({out_valid, contact, rung_out}, 3'h0)
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) begin
            @(posedge clk);
            #1 `CHK(out_valid, 1'h0)
        end
        @(posedge clk);
        #1 chk_row(rows[1]);
        $display("reset test done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
